// file: design/tms_pkg.sv
/*
 Shared constants for the temperature monitor management-bus link:
 bus codes, register selectors, reset values, field positions.
 Assumes both ends run on one 40 MHz clock.
*/
package tms_pkg;
	// Bus framing
	localparam int          BYTE_BITS     = 8;
	localparam int          ADDR_BITS     = 7;
	localparam logic        BIT_WRITE     = 1'b0;
	localparam logic        BIT_READ      = 1'b1;
	// Register selectors held in the command pointer
	localparam logic [7:0]  CMD_LOCAL_T   = 8'h00;
	localparam logic [7:0]  CMD_REMOTE_T  = 8'h01;
	localparam logic [7:0]  CMD_STATUS    = 8'h02;
	localparam logic [7:0]  CMD_RD_RATE   = 8'h04;
	localparam logic [7:0]  CMD_RD_LHI    = 8'h05;
	localparam logic [7:0]  CMD_RD_LLO    = 8'h06;
	localparam logic [7:0]  CMD_RD_RHI    = 8'h07;
	localparam logic [7:0]  CMD_RD_RLO    = 8'h08;
	localparam logic [7:0]  CMD_WR_RATE   = 8'h0a;
	localparam logic [7:0]  CMD_WR_LHI    = 8'h0b;
	localparam logic [7:0]  CMD_WR_LLO    = 8'h0c;
	localparam logic [7:0]  CMD_WR_RHI    = 8'h0d;
	localparam logic [7:0]  CMD_WR_RLO    = 8'h0e;
	localparam logic [7:0]  SINGLE_CONV_CMD = 8'h0f;
	// Reset values
	localparam logic [7:0]  RATE_RESET    = 8'h02;
	localparam logic [7:0]  RATE_MAX      = 8'h07;
	localparam logic [7:0]  HI_LIMIT_RESET = 8'h7f;
	localparam logic [7:0]  LO_LIMIT_RESET = 8'hc9;
	localparam logic [7:0]  PTR_RESET     = 8'h00;
	localparam logic [7:0]  FAULT_TEMP    = 8'h7f;
	// Status fields
	localparam int          ST_BUSY       = 7;
	localparam int          REMOTE_HIGH_FLAG_BIT = 4;
	localparam int          OPEN_DIODE_FLAG_BIT  = 2;
	// Host timing: bus clock half period in clk cycles (5 us at 40 MHz)
	localparam int          CLK_MHZ       = 40;
	localparam int          HALF_NS       = 5000;
	localparam int          HALF_CYC      = (HALF_NS * CLK_MHZ) / 1000;
	// Conversion length, base rate period (16 s) in clk cycles
	localparam int          CONV_CYC_DEF  = 6800000;
	localparam int          RATE_BASE_DEF = 640000000;
	// Host commands
	localparam logic [1:0]  OP_WRITE      = 2'h0;
	localparam logic [1:0]  OP_READ       = 2'h1;
	localparam logic [1:0]  OP_SEND       = 2'h2;
	localparam logic [1:0]  OP_RECV       = 2'h3;
endpackage

// file: design/tms_bus_if.sv
/*
 Two-wire management bus between master and monitor.
 Both wires are open-drain; wire levels are resolved here from enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface tms_bus_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_s;
	logic alert_oe_s;
	logic scl;
	logic serial_bus_data_pin;
	logic alert_n;
	// Low wins: an enabled driver pulls the wire down
	assign scl                 = ~scl_oe_m;
	assign serial_bus_data_pin = ~(sda_oe_m | sda_oe_s);
	assign alert_n             = ~alert_oe_s;
	modport master (output scl_oe_m, output sda_oe_m,
		input scl, input serial_bus_data_pin, input alert_n);
	modport slave (output sda_oe_s, output alert_oe_s,
		input scl, input serial_bus_data_pin);
endinterface
`default_nettype wire

// file: design/tms_slave.sv
/*
 Temperature monitor bus slave: protocol engine, command pointer,
 limit and rate registers, conversion timing and diode fault capture.
 Assumes bus wires from another domain; temperature values and diode
 state come from analog logic on clk_in.
*/
// Contract
// - Reset releases alert latch
// - Reset rate code is quarter hertz
// - Reset limits +127 high, -55 low
// - Reset pointer selects local reading
// - Check diode at every conversion start
// - Diode fault: alert, 127, flags
// - Write byte acked, data stored
// - Read byte returns selected register
// - Send byte acked, command acted on
// - Receive byte returns current register
// - Pointer kept across transfers
// - Master frames with start, stop
// - Nine clocks per byte, MSB first
// - Respond only to own address
// - Command byte loads pointer
// - Four protocols, clock and data pin
// - Single conversion ignored busy/standby
// - Open and high flags, reset zero
// - Rate codes 0-7, others reserved
`timescale 1ns/1ps
`default_nettype none
module tms_slave
	import tms_pkg::*;
#(
	parameter int CONV_CYC  = CONV_CYC_DEF,
	parameter int RATE_BASE = RATE_BASE_DEF
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Bus
	tms_bus_if.slave        bus,
	// Device side
	input  wire logic [6:0] own_addr_in,
	input  wire logic       hw_standby_in,
	input  wire logic [7:0] local_temp_in,
	input  wire logic [7:0] remote_temp_in,
	input  wire logic       diode_open_in,
	input  wire logic       diode_short_in,
	output logic            conv_busy_out,
	output logic [7:0]      local_temp_reading_out,
	output logic [7:0]      remote_temp_reading_out,
	output logic [7:0]      rate_out
);
	initial begin
		if (CONV_CYC < 2 || RATE_BASE < 256)
			$error("tms_slave: bad conversion timing");
	end
	typedef enum logic [5:0] {
		S_IDLE = 6'h01, S_ADDR = 6'h02, S_AACK = 6'h04,
		S_RX   = 6'h08, S_TX   = 6'h10, S_MACK = 6'h20
	} tms_state_t;
	////////////////////////////////////////////////////////////////
	// Synchronisers and edge detect
	logic [1:0] scl_s_q, sda_s_q, stby_s_q;
	logic       scl_p_q, sda_p_q;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			stby_s_q <= 2'h0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], bus.scl};
			sda_s_q <= {sda_s_q[0], bus.serial_bus_data_pin};
			stby_s_q <= {stby_s_q[0], hw_standby_in};
			scl_p_q <= scl_s_q[1];
			sda_p_q <= sda_s_q[1];
		end
	end
	logic scl_w, sda_w, scl_rise, scl_fall, start_c, stop_c;
	assign scl_w    = scl_s_q[1];
	assign sda_w    = sda_s_q[1];
	assign scl_rise = scl_w & ~scl_p_q;
	assign scl_fall = ~scl_w & scl_p_q;
	assign start_c  = scl_w & scl_p_q & sda_p_q & ~sda_w;
	assign stop_c   = scl_w & scl_p_q & ~sda_p_q & sda_w;
	////////////////////////////////////////////////////////////////
	// Protocol engine and register file
	tms_state_t st_q, st_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rate_q, rate_d;
	logic [7:0] lhi_q, lhi_d, llo_q, llo_d, rhi_q, rhi_d, rlo_q, rlo_d;
	logic [3:0] cnt_q, cnt_d;
	logic       rd_q, rd_d, first_q, first_d, sda_q, sda_d, oneshot;
	logic       st_clr;
	logic [7:0] status_q;
	function automatic logic [7:0] rd_mux(input logic [7:0] sel);
		unique case (sel)
			CMD_LOCAL_T:  rd_mux = local_temp_reading_out;
			CMD_REMOTE_T: rd_mux = remote_temp_reading_out;
			CMD_STATUS:   rd_mux = status_q;
			CMD_RD_RATE:  rd_mux = rate_q;
			CMD_RD_LHI:   rd_mux = lhi_q;
			CMD_RD_LLO:   rd_mux = llo_q;
			CMD_RD_RHI:   rd_mux = rhi_q;
			CMD_RD_RLO:   rd_mux = rlo_q;
			default:      rd_mux = 8'h00;
		endcase
	endfunction
	always_comb begin
		st_d = st_q; sh_d = sh_q; cnt_d = cnt_q; rd_d = rd_q;
		first_d = first_q; sda_d = sda_q; ptr_d = ptr_q;
		rate_d = rate_q; lhi_d = lhi_q; llo_d = llo_q;
		rhi_d = rhi_q; rlo_d = rlo_q; oneshot = 1'b0; st_clr = 1'b0;
		if (start_c) begin
			st_d = S_ADDR; cnt_d = 4'h0; sda_d = 1'b0;
		end else if (stop_c) begin
			st_d = S_IDLE; sda_d = 1'b0;
			// Command without data byte; foreign frames stay idle
			if (st_q == S_RX && !rd_q && !first_q && ptr_q == SINGLE_CONV_CMD)
				oneshot = 1'b1;
		end else begin
			unique case (st_q)
				S_IDLE: ;
				S_ADDR: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_w};
						cnt_d = cnt_q + 4'h1;
					end
					if (scl_fall && cnt_q == 4'(BYTE_BITS)) begin
						if (sh_q[7:1] == own_addr_in) begin
							sda_d = 1'b1; rd_d = sh_q[0]; first_d = 1'b1;
							st_d = S_AACK;
						end else begin
							st_d = S_IDLE;
						end
					end
				end
				S_AACK: if (scl_fall) begin
					cnt_d = 4'h0;
					if (rd_q == BIT_READ) begin
						sh_d = rd_mux(ptr_q);
						sda_d = ~sh_d[7];
						st_d = S_TX;
					end else begin
						sda_d = 1'b0; st_d = S_RX;
					end
				end
				S_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_w};
						cnt_d = cnt_q + 4'h1;
					end
					if (scl_fall && cnt_q == 4'(BYTE_BITS)) begin
						sda_d = 1'b1; st_d = S_AACK; rd_d = BIT_WRITE;
						first_d = 1'b0;
						if (first_q) begin
							ptr_d = sh_q;
						end else begin
							unique case (ptr_q)
								CMD_WR_RATE: rate_d = sh_q;
								CMD_WR_LHI:  lhi_d = sh_q;
								CMD_WR_LLO:  llo_d = sh_q;
								CMD_WR_RHI:  rhi_d = sh_q;
								CMD_WR_RLO:  rlo_d = sh_q;
								default: ;
							endcase
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == 4'(BYTE_BITS - 1)) begin
							sda_d = 1'b0; st_d = S_MACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							sda_d = ~sh_q[6];
						end
					end
				end
				S_MACK: if (scl_rise) begin
					if (ptr_q == CMD_STATUS)
						st_clr = 1'b1;
					// Master nack ends the byte; ack just resends
					st_d = sda_w ? S_IDLE : S_AACK;
				end
				default: st_d = S_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= S_IDLE; sh_q <= 8'h00; cnt_q <= 4'h0;
			rd_q <= 1'b0; first_q <= 1'b0; sda_q <= 1'b0;
			ptr_q <= PTR_RESET;
			rate_q <= RATE_RESET;
			lhi_q <= HI_LIMIT_RESET;
			rhi_q <= HI_LIMIT_RESET;
			llo_q <= LO_LIMIT_RESET;
			rlo_q <= LO_LIMIT_RESET;
		end else begin
			st_q <= st_d; sh_q <= sh_d; cnt_q <= cnt_d; rd_q <= rd_d;
			first_q <= first_d; sda_q <= sda_d; ptr_q <= ptr_d;
			rate_q <= rate_d; lhi_q <= lhi_d; llo_q <= llo_d;
			rhi_q <= rhi_d; rlo_q <= rlo_d;
		end
	end
	////////////////////////////////////////////////////////////////
	// Conversion timing and fault capture
	logic [31:0] per_q, per_d, cv_q, cv_d;
	logic        busy_q, busy_d, alert_q, alert_d, go;
	logic [7:0]  loc_q, loc_d, rem_q, rem_d, stat_d;
	logic [31:0] period;
	// Reserved codes fall back to slowest rate
	assign period = (rate_q > RATE_MAX) ? 32'(RATE_BASE) :
		32'(RATE_BASE) >> rate_q[2:0];
	always_comb begin
		per_d = per_q + 32'h1; cv_d = cv_q; busy_d = busy_q;
		alert_d = alert_q; loc_d = loc_q; rem_d = rem_q;
		stat_d = status_q;
		go = (per_q >= period - 32'h1) |
			(oneshot & ~busy_q & ~stby_s_q[1]);
		if (st_clr)
			stat_d[6:0] = 7'h00;
		if (go && !busy_q) begin
			per_d = 32'h0; busy_d = 1'b1; cv_d = 32'h0;
			if (diode_open_in | diode_short_in) begin
				alert_d = 1'b1;
				stat_d[REMOTE_HIGH_FLAG_BIT] = 1'b1;
				if (diode_open_in)
					stat_d[OPEN_DIODE_FLAG_BIT] = 1'b1;
			end
		end else if (busy_q) begin
			cv_d = cv_q + 32'h1;
			if (cv_q == 32'(CONV_CYC - 1)) begin
				busy_d = 1'b0; loc_d = local_temp_in;
				rem_d = (diode_open_in | diode_short_in) ?
					FAULT_TEMP : remote_temp_in;
				if (diode_open_in | diode_short_in)
					stat_d[REMOTE_HIGH_FLAG_BIT] = 1'b1;
			end
		end
		stat_d[ST_BUSY] = busy_d;
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			per_q <= 32'h0; cv_q <= 32'h0; busy_q <= 1'b0;
			alert_q <= 1'b0;
			loc_q <= 8'h00; rem_q <= 8'h00;
			status_q <= 8'h00;
		end else begin
			per_q <= per_d; cv_q <= cv_d; busy_q <= busy_d;
			alert_q <= alert_d; loc_q <= loc_d; rem_q <= rem_d;
			status_q <= stat_d;
		end
	end
	assign bus.sda_oe_s             = sda_q;
	assign bus.alert_oe_s           = alert_q;
	assign conv_busy_out            = busy_q;
	assign local_temp_reading_out   = loc_q;
	assign remote_temp_reading_out  = rem_q;
	assign rate_out                 = rate_q;
endmodule
`default_nettype wire

// file: design/tms_master.sv
/*
 Management-bus master: runs one of the four byte protocols per
 order from a plain register port. Assumes slave on tms_bus_if.
 Regs: 0 ctrl(wr: [1:0] op, bit4 go), 1 addr, 2 command, 3 wdata,
 4 rdata, 5 status (bit0 busy, bit1 nack seen).
*/
`timescale 1ns/1ps
`default_nettype none
module tms_master
	import tms_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Bus
	tms_bus_if.master       bus,
	// Register port
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out
);
	typedef enum logic [3:0] {
		M_IDLE = 4'h1, M_START = 4'h2, M_BIT = 4'h4, M_STOP = 4'h8
	} tms_mstate_t;
	////////////////////////////////////////////////////////////////
	logic [1:0] sda_s_q;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			sda_s_q <= 2'h3;
		else
			sda_s_q <= {sda_s_q[0], bus.serial_bus_data_pin};
	end
	tms_mstate_t st_q, st_d;
	logic [1:0]  op_q, op_d, ph_q, ph_d;
	logic [6:0]  adr_q, adr_d;
	logic [7:0]  cmd_q, cmd_d, wd_q, wd_d, rdat_q, rdat_d, sh_q, sh_d;
	logic [7:0]  rdo_q, rdo_d;
	logic [3:0]  bit_q, bit_d;
	logic [2:0]  byt_q, byt_d, nby_q, nby_d;
	logic [15:0] tm_q, tm_d;
	logic        scl_q, scl_d, sda_q, sda_d, nack_q, nack_d, tick;
	logic        rx_q, rx_d;
	assign tick = (tm_q == 16'(HALF_CYC - 1));
	// Byte n of the frame for each op; 0xff fills byte 3, a receive slot
	function automatic logic [7:0] frame_byte(input logic [2:0] n);
		unique case (n)
			3'h0: frame_byte = {adr_q, (op_q == OP_RECV)};
			3'h1: frame_byte = cmd_q;
			3'h2: frame_byte = (op_q == OP_READ) ?
				{adr_q, BIT_READ} : wd_q;
			default: frame_byte = 8'hff;
		endcase
	endfunction
	always_comb begin
		st_d = st_q; op_d = op_q; adr_d = adr_q; cmd_d = cmd_q;
		wd_d = wd_q; rdat_d = rdat_q; sh_d = sh_q; bit_d = bit_q;
		byt_d = byt_q; nby_d = nby_q; tm_d = tick ? 16'h0 : tm_q + 16'h1;
		scl_d = scl_q; sda_d = sda_q; nack_d = nack_q; ph_d = ph_q;
		rx_d = rx_q; rdo_d = 8'h00;
		if (rd_in) begin
			unique case (addr_in)
				3'h1: rdo_d = {1'b0, adr_q};
				3'h2: rdo_d = cmd_q;
				3'h3: rdo_d = wd_q;
				3'h4: rdo_d = rdat_q;
				3'h5: rdo_d = {6'h00, nack_q, (st_q != M_IDLE)};
				default: rdo_d = {6'h00, op_q};
			endcase
		end
		if (wr_in && st_q == M_IDLE) begin
			unique case (addr_in)
				3'h0: begin
					op_d = wdata_in[1:0];
					if (wdata_in[4]) begin
						st_d = M_START; ph_d = 2'h0; tm_d = 16'h0;
						nack_d = 1'b0; byt_d = 3'h0;
						unique case (wdata_in[1:0])
							OP_WRITE: nby_d = 3'h3;
							OP_READ:  nby_d = 3'h4;
							OP_SEND:  nby_d = 3'h2;
							default:  nby_d = 3'h2;
						endcase
					end
				end
				3'h1: adr_d = wdata_in[6:0];
				3'h2: cmd_d = wdata_in;
				3'h3: wd_d = wdata_in;
				default: ;
			endcase
		end else if (tick) begin
			unique case (st_q)
				M_IDLE: begin
					scl_d = 1'b0; sda_d = 1'b0;
				end
				M_START: begin
					// Phases: release, pull data, pull clock
					ph_d = ph_q + 2'h1;
					if (ph_q == 2'h0) begin
						scl_d = 1'b0; sda_d = 1'b0;
					end else if (ph_q == 2'h1) begin
						sda_d = 1'b1;
					end else begin
						scl_d = 1'b1; st_d = M_BIT; bit_d = 4'h0;
						sh_d = frame_byte(byt_q);
						rx_d = (op_q == OP_RECV && byt_q == 3'h1) ||
							(op_q == OP_READ && byt_q == 3'h3);
						sda_d = rx_d ? 1'b0 : ~sh_d[7];
					end
				end
				M_BIT: begin
					scl_d = ~scl_q;
					if (!scl_q) begin
						// Clock high: sample, then move data as clock falls,
						// so data never changes under a high clock
						bit_d = bit_q + 4'h1;
						if (bit_q == 4'h8) begin
							if (!rx_q && sda_s_q[1])
								nack_d = 1'b1;
							byt_d = byt_q + 3'h1;
							if (byt_d == nby_q || nack_d) begin
								st_d = M_STOP; sda_d = 1'b1; ph_d = 2'h0;
							end else if (op_q == OP_READ && byt_q == 3'h1) begin
								st_d = M_START; ph_d = 2'h0; sda_d = 1'b0;
							end else begin
								bit_d = 4'h0; sh_d = frame_byte(byt_d);
								rx_d = (op_q == OP_RECV) ||
									(op_q == OP_READ && byt_d == 3'h3);
								sda_d = rx_d ? 1'b0 : ~sh_d[7];
							end
						end else begin
							rdat_d = rx_q ? {rdat_q[6:0], sda_s_q[1]} :
								rdat_q;
							if (bit_q == 4'h7) begin
								// Ack slot: receiver acks writes, nack on read
								sda_d = 1'b0;
							end else begin
								sh_d = {sh_q[6:0], 1'b0};
								sda_d = rx_q ? 1'b0 : ~sh_q[6];
							end
						end
					end
				end
				M_STOP: begin
					ph_d = ph_q + 2'h1;
					if (ph_q == 2'h0)
						scl_d = 1'b0;
					else begin
						sda_d = 1'b0; st_d = M_IDLE;
					end
				end
				default: st_d = M_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= M_IDLE; op_q <= 2'h0; adr_q <= 7'h00; cmd_q <= 8'h00;
			wd_q <= 8'h00; rdat_q <= 8'h00; sh_q <= 8'h00; bit_q <= 4'h0;
			byt_q <= 3'h0; nby_q <= 3'h0; tm_q <= 16'h0; scl_q <= 1'b0;
			sda_q <= 1'b0; nack_q <= 1'b0; ph_q <= 2'h0; rx_q <= 1'b0;
			rdo_q <= 8'h00;
		end else begin
			st_q <= st_d; op_q <= op_d; adr_q <= adr_d; cmd_q <= cmd_d;
			wd_q <= wd_d; rdat_q <= rdat_d; sh_q <= sh_d; bit_q <= bit_d;
			byt_q <= byt_d; nby_q <= nby_d; tm_q <= tm_d; scl_q <= scl_d;
			sda_q <= sda_d; nack_q <= nack_d; ph_q <= ph_d; rx_q <= rx_d;
			rdo_q <= rdo_d;
		end
	end
	assign bus.scl_oe_m = scl_q;
	assign bus.sda_oe_m = sda_q;
	assign rdata_out    = rdo_q;
endmodule
`default_nettype wire

// file: tb/tms_bus_checker.sv
/*
 Concurrent checks on the management-bus wires seen by the monitor end.
 Assumes bus wires change only on clk_in edges and one slave on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tms_bus_checker (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Bus wires and slave enables
	input  wire logic       sda_oe_s,
	input  wire logic       alert_oe_s,
	input  wire logic       scl,
	input  wire logic       serial_bus_data_pin,
	// Slave address strap
	input  wire logic [6:0] own_addr_in
);
	logic       scl_q, sda_q, rw_q, ign_q, frame_q;
	logic [3:0] bit_q, low_q;
	logic [2:0] byte_q;
	logic [6:0] addr_q;
	logic       rise, start, stop;
	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~serial_bus_data_pin;
	assign stop  = scl & scl_q & ~sda_q & serial_bus_data_pin;
	////////////////////////////////////////////////////////////////////
	// Frame tracking: bit and byte position since the last start
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{scl_q, sda_q} <= 2'b11;
			{rw_q, ign_q, frame_q} <= 3'b000;
			bit_q  <= 4'h0;
			low_q  <= 4'h0;
			byte_q <= 3'h0;
			addr_q <= 7'h00;
		end else begin
			scl_q <= scl;
			sda_q <= serial_bus_data_pin;
			low_q <= scl ? 4'h0 : (low_q == 4'hf ? low_q : low_q + 4'h1);
			if (start) begin
				{ign_q, frame_q} <= 2'b01;
				bit_q  <= 4'h0;
				byte_q <= 3'h0;
			end else if (stop) begin
				frame_q <= 1'b0;
			end else if (rise) begin
				bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
				if (bit_q == 4'h8)
					byte_q <= byte_q + 3'h1;
				if (bit_q == 4'h8 && byte_q == 3'h0 && addr_q != own_addr_in)
					ign_q <= 1'b1;
				if (byte_q == 3'h0 && bit_q < 4'h7)
					addr_q <= {addr_q[5:0], serial_bus_data_pin};
				if (byte_q == 3'h0 && bit_q == 4'h7)
					rw_q <= serial_bus_data_pin;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence ack_slot;
		rise && frame_q && bit_q == 4'h8;
	endsequence
	a_alert_reset: assert property ($rose(rstn_in) |-> !alert_oe_s)
		else $error("alert driven right after reset");
	a_alert_latch: assert property (alert_oe_s |=> alert_oe_s)
		else $error("alert latch let go");
	a_idle_released: assert property (!frame_q |-> !sda_oe_s)
		else $error("slave drives data outside a frame");
	a_addr_match: assert property (ack_slot ##0 byte_q == 3'h0
		|-> sda_oe_s == (addr_q == own_addr_in))
		else $error("address acknowledge wrong");
	a_ignore_foreign: assert property (ign_q |-> !sda_oe_s)
		else $error("slave drives after foreign address");
	a_write_acked: assert property (ack_slot ##0
		(byte_q != 3'h0 && !rw_q && !ign_q) |-> sda_oe_s)
		else $error("written byte not acknowledged");
	a_read_release: assert property (ack_slot ##0
		(byte_q != 3'h0 && rw_q) |-> !sda_oe_s)
		else $error("slave holds data in master ack slot");
	a_stable_high: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
		else $error("slave data changed while clock high");
	a_answer_prompt: assert property ($changed(sda_oe_s)
		|-> !scl && low_q < 4'h8)
		else $error("slave data changed late in clock low");
endmodule
`default_nettype wire

// file: tb/temp_monitor_smbus_slave_tb.sv
/*
 Self-checking bench: master and monitor face each other over the bus.
 Assumes short conversion and rate parameters for simulation speed.
*/
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_smbus_slave_tb;
	import tms_pkg::*;
	localparam int CONV  = 20;
	localparam int LIMIT = 98000;
	logic       clk_in, rstn_in, hw_standby, diode_open, diode_short;
	logic       conv_busy, m_wr, m_rd;
	logic [6:0] own_addr;
	logic [7:0] local_t, remote_t, local_rd, remote_rd, rate;
	logic [7:0] m_wdata, m_rdata;
	logic [2:0] m_addr;
	logic [31:0] seed;
	int         checks, miscompares, cycles;
	////////////////////////////////////////////////////////////////////
	tms_bus_if tms_bus_if_i ();
	tms_slave #(.CONV_CYC(CONV), .RATE_BASE(5120)) tms_slave_i (
		.clk_in(clk_in), .rstn_in(rstn_in), .bus(tms_bus_if_i),
		.own_addr_in(own_addr), .hw_standby_in(hw_standby),
		.local_temp_in(local_t), .remote_temp_in(remote_t),
		.diode_open_in(diode_open), .diode_short_in(diode_short),
		.conv_busy_out(conv_busy), .local_temp_reading_out(local_rd),
		.remote_temp_reading_out(remote_rd), .rate_out(rate));
	tms_master tms_master_i (
		.clk_in(clk_in), .rstn_in(rstn_in), .bus(tms_bus_if_i),
		.addr_in(m_addr), .wdata_in(m_wdata), .wr_in(m_wr),
		.rd_in(m_rd), .rdata_out(m_rdata));
	tms_bus_checker tms_bus_checker_i (
		.clk_in(clk_in), .rstn_in(rstn_in),
		.sda_oe_s(tms_bus_if_i.sda_oe_s),
		.alert_oe_s(tms_bus_if_i.alert_oe_s), .scl(tms_bus_if_i.scl),
		.serial_bus_data_pin(tms_bus_if_i.serial_bus_data_pin),
		.own_addr_in(own_addr));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Limit selectors 05..08 alternate high and low
	function automatic logic [7:0] lim_exp(input logic [1:0] idx);
		return idx[0] ? LO_LIMIT_RESET : HI_LIMIT_RESET;
	endfunction
	// Busy bit masked off: it moves with free-running conversions
	function automatic logic [7:0] st_exp(input logic open);
		return {3'b000, 1'b1, 1'b0, open, 2'b00};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		m_addr  <= a;
		m_wdata <= d;
		m_wr    <= 1'b1;
		@(posedge clk_in);
		m_wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_in);
		m_addr <= a;
		m_rd   <= 1'b1;
		@(posedge clk_in);
		m_rd <= 1'b0;
		#1 d = m_rdata;
	endtask
	task automatic bus_op(input logic [1:0] op, input logic [6:0] a,
		input logic [7:0] cmd, input logic [7:0] wd,
		output logic [7:0] rx, output logic nk);
		logic [7:0] s;
		int         n;
		reg_wr(3'h1, {1'b0, a});
		reg_wr(3'h2, cmd);
		reg_wr(3'h3, wd);
		reg_wr(3'h0, {6'h04, op});
		n = 0;
		do begin
			reg_rd(3'h5, s);
			n++;
		end while (s[0] !== 1'b0 && n < 20000);
		check({7'h00, s[0]}, 8'h00);
		reg_rd(3'h4, rx);
		nk = s[1];
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Hang guard: counts as a mismatch
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		logic [7:0] rx;
		logic [2:0] r;
		logic       nk;
		int         n;
		{checks, miscompares, cycles} = '0;
		seed = xs(32'heddd);
		own_addr = seed[6:0];
		// Small positive temperatures keep limit flags quiet
		local_t  = {2'b00, seed[13:8]};
		remote_t = {2'b00, seed[21:16]};
		{rstn_in, hw_standby, diode_open, diode_short} = 4'h0;
		{m_wr, m_rd, m_addr, m_wdata} = '0;
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		check({7'h00, tms_bus_if_i.alert_n}, 8'h01);
		check(rate, RATE_RESET);
		bus_op(OP_RECV, own_addr, 8'h00, 8'h00, rx, nk);
		check(rx, local_t);
		check(local_rd, local_t);
		check({7'h00, nk}, 8'h00);
		$display("test reset_defaults done");
		seed = xs(seed);
		bus_op(OP_READ, own_addr, CMD_RD_LHI + {6'h00, seed[1:0]}, 8'h00, rx, nk);
		check(rx, lim_exp(seed[1:0]));
		check({7'h00, nk}, 8'h00);
		bus_op(OP_RECV, own_addr, 8'h00, 8'h00, rx, nk);
		check(rx, lim_exp(seed[1:0]));
		$display("test pointer_kept done");
		r = seed[4:2];
		bus_op(OP_WRITE, own_addr, CMD_WR_RATE, {5'h00, r}, rx, nk);
		check(rate, {5'h00, r});
		check({7'h00, nk}, 8'h00);
		bus_op(OP_SEND, own_addr ^ 7'h01, SINGLE_CONV_CMD, 8'h00, rx, nk);
		check({7'h00, nk}, 8'h01);
		bus_op(OP_SEND, own_addr, SINGLE_CONV_CMD, 8'h00, rx, nk);
		check({7'h00, nk}, 8'h00);
		$display("test write_send done");
		@(posedge clk_in);
		diode_open <= 1'b1;
		n = 0;
		while (tms_bus_if_i.alert_n !== 1'b0 && n < 6000) begin
			@(posedge clk_in);
			n++;
		end
		check({7'h00, tms_bus_if_i.alert_n}, 8'h00);
		check({7'h00, conv_busy}, 8'h01);
		repeat (2 * CONV) @(posedge clk_in);
		check(remote_rd, FAULT_TEMP);
		bus_op(OP_READ, own_addr, CMD_STATUS, 8'h00, rx, nk);
		check(rx & 8'h7f, st_exp(1'b1));
		$display("test open_diode done");
		@(posedge clk_in);
		diode_open <= 1'b0;
		rstn_in    <= 1'b0;
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		check({7'h00, tms_bus_if_i.alert_n}, 8'h01);
		check(rate, RATE_RESET);
		bus_op(OP_RECV, own_addr, 8'h00, 8'h00, rx, nk);
		check(rx, local_t);
		$display("test second_reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
